/* core/pwm_output_stage.sv */
// Top of the six-channel PWM output stage: setting registers and per-leg shaping.
// Assumes a byte-wide host control port on core_clk and raw modulator levels from core logic.
`timescale 1ns/1ps
`include "pwm_stage_map.svh"
module pwm_output_stage
	import pwm_stage_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic modulator_power_down,
	input wire logic mclk_en,
	input wire logic [5:0] mod_level,
	output logic oversample_rate_select,
	output logic [5:0] positive_output,
	output logic [5:0] negative_output,
	output logic [5:0] negative_enable
);
	// Channel order: bit 0 A1, 1 B1, 2 A2, 3 B2, 4 A3, 5 B3.
	typedef struct packed {
		reg_byte_t cfg;
		reg_byte_t minp;
		reg_byte_t dly;
		reg_byte_t act_cfg;
		reg_byte_t act_minp;
		reg_byte_t act_dly;
		reg_byte_t rdata;
		logic rate;
		chan_vec_t pos;
		chan_vec_t neg;
		chan_vec_t neg_en;
	} top_state_t;
	top_state_t q, d;
	chan_vec_t full_bridge;
	chan_vec_t pos_shaped;
	chan_vec_t neg_shaped;
	logic run;
	logic wr_open;
	logic wr_cfg;
	logic wr_minp;
	logic wr_dly;
	reg_byte_t rd_value;
	logic [4:0] act_min_pulse;
	logic [2:0] act_leg_skew;
	logic [4:0] act_pair_skew;
	logic act_minus_disable;
	logic act_rate;
	chan_vec_t neg_drive;
	chan_vec_t pos_next;
	chan_vec_t neg_next;

	// Power-down doubles as the run gate: legs and leg outputs are held in reset while it is high.
	assign run = !modulator_power_down;

	// A write only counts while the modulators are powered down; other strobes are dropped.
	assign wr_open = reg_wr && modulator_power_down;
	assign wr_cfg = wr_open && (reg_addr == `ADDR_CONFIGURATION);
	assign wr_minp = wr_open && (reg_addr == `ADDR_MIN_PULSE);
	assign wr_dly = wr_open && (reg_addr == `ADDR_OUTPUT_DELAY);

	// Fields of the active copies, which the legs see while running.
	assign act_min_pulse = q.act_minp[`MINP_MSB:`MINP_LSB];
	assign act_minus_disable = q.act_minp[`MINP_DISABLE_BIT];
	assign act_leg_skew = q.act_dly[`DLY_LEG_MSB:`DLY_LEG_LSB];
	assign act_pair_skew = q.act_dly[`DLY_PAIR_MSB:`DLY_PAIR_LSB];
	assign act_rate = q.act_cfg[`CFG_RATE_BIT];

	// Reads return the stored byte; reserved bits were masked to zero when it was written.
	always_comb begin
		unique case (reg_addr)
			`ADDR_CONFIGURATION: rd_value = q.cfg;
			`ADDR_MIN_PULSE: rd_value = q.minp;
			`ADDR_OUTPUT_DELAY: rd_value = q.dly;
			default: rd_value = `REG_RESET;
		endcase
	end

	always_comb begin
		full_bridge[0] = q.act_cfg[`CFG_PAIR1_BIT];
		full_bridge[1] = q.act_cfg[`CFG_PAIR1_BIT];
		full_bridge[2] = q.act_cfg[`CFG_PAIR2_BIT];
		full_bridge[3] = q.act_cfg[`CFG_PAIR2_BIT];
		full_bridge[4] = q.act_cfg[`CFG_A3_BIT];
		full_bridge[5] = q.act_cfg[`CFG_B3_BIT];
	end

	genvar ch;
	generate
		for (ch = 0; ch < 6; ch++) begin : g_chan
			// A channels (even index) lag their B partner by the pair skew.
			logic [5:0] pair_dly;
			logic [5:0] leg_dly;
			logic neg_src;
			assign pair_dly = (ch % 2 == 0) ? {1'b0, act_pair_skew} : `DLY_NONE;
			assign leg_dly = pair_dly + {3'h0, act_leg_skew};
			// Full-bridge channels, and half-bridge ones while minus disable is clear, drive the minus leg as the complement of the modulator level.
			assign neg_src = !mod_level[ch];
			assign neg_drive[ch] = run && (full_bridge[ch] || !act_minus_disable);
			assign pos_next[ch] = run && pos_shaped[ch];
			assign neg_next[ch] = neg_drive[ch] && neg_shaped[ch];
			pwm_leg_shaper u_pos (
				.core_clk(core_clk),
				.nrst(nrst),
				.mclk_en(mclk_en),
				.run(run),
				.level_in(mod_level[ch]),
				.min_pulse(act_min_pulse),
				.delay(pair_dly),
				.level_out(pos_shaped[ch])
			);
			pwm_leg_shaper u_neg (
				.core_clk(core_clk),
				.nrst(nrst),
				.mclk_en(mclk_en),
				.run(run),
				.level_in(neg_src),
				.min_pulse(act_min_pulse),
				.delay(leg_dly),
				.level_out(neg_shaped[ch])
			);
		end
	endgenerate

	always_comb begin
		d = q;
		// Settings are locked while the modulators run, so a half-written setup never reaches the legs.
		if (wr_cfg) begin
			d.cfg = reg_wdata & `CFG_WRITE_MASK;
		end
		if (wr_minp) begin
			d.minp = reg_wdata & `MINP_WRITE_MASK;
		end
		if (wr_dly) begin
			d.dly = reg_wdata;
		end
		// The active copies follow the written bytes only while powered down.
		if (modulator_power_down) begin
			d.act_cfg = d.cfg;
			d.act_minp = d.minp;
			d.act_dly = d.dly;
		end
		if (reg_rd) begin
			d.rdata = rd_value;
		end
		d.rate = act_rate;
		d.pos = pos_next;
		d.neg = neg_next;
		d.neg_en = ~neg_drive;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.neg_en <= `NEG_EN_IDLE;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign oversample_rate_select = q.rate;
	assign positive_output = q.pos;
	assign negative_output = q.neg;
	assign negative_enable = q.neg_en;
endmodule : pwm_output_stage

/* core/pwm_stage_map.svh */
// Register map, field positions, reset values and timing counts of the PWM output stage.
// Assumes an 8-bit host control port with a byte address and single-cycle write/read strobes.
`ifndef PWM_STAGE_MAP_SVH
`define PWM_STAGE_MAP_SVH
`define ADDR_CONFIGURATION 8'h31
`define ADDR_MIN_PULSE 8'h32
`define ADDR_OUTPUT_DELAY 8'h33
`define CFG_WRITE_MASK 8'h9E
`define MINP_WRITE_MASK 8'h9F
`define CFG_RATE_BIT 7
`define CFG_PAIR1_BIT 4
`define CFG_PAIR2_BIT 3
`define CFG_A3_BIT 2
`define CFG_B3_BIT 1
`define MINP_DISABLE_BIT 7
`define MINP_LSB 0
`define MINP_MSB 4
`define DLY_LEG_LSB 5
`define DLY_LEG_MSB 7
`define DLY_PAIR_LSB 0
`define DLY_PAIR_MSB 4
`define REG_RESET 8'h00
`define DLY_DEPTH 38
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define CNT_MAX 5'h1F
`define DLY_NONE 6'h00
`define DLY_ONE 6'h01
`define NEG_EN_IDLE 6'h3F
`endif

/* core/pwm_stage_pkg.sv */
// Types shared by the PWM output stage modules.
// Assumes the map header is included alongside it.
package pwm_stage_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [5:0] chan_vec_t;
endpackage : pwm_stage_pkg

/* core/pwm_leg_shaper.sv */
// One channel's leg: minimum pulse hold, then a tapped delay line for skew.
// Assumes the mclk enable pulse and settings come from the same clock domain.
`timescale 1ns/1ps
`include "pwm_stage_map.svh"
module pwm_leg_shaper
	import pwm_stage_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic mclk_en,
	input wire logic run,
	input wire logic level_in,
	input wire logic [4:0] min_pulse,
	input wire logic [5:0] delay,
	output logic level_out
);
	typedef struct packed {
		logic held;
		logic [4:0] age;
		logic [`DLY_DEPTH-1:0] line;
	} leg_state_t;
	leg_state_t q, d;

	always_comb begin
		d = q;
		if (!run) begin
			d = '0;
		end else if (mclk_en) begin
			// The level may only change once it has been held for the minimum period count.
			if (level_in != q.held && q.age >= min_pulse) begin
				d.held = level_in;
				d.age = `CNT_ONE;
			end else if (q.age != `CNT_MAX) begin
				d.age = q.age + `CNT_ONE;
			end
			// Tap zero takes the level held before this period, so tap k-1 lags by k periods.
			d.line = {q.line[`DLY_DEPTH-2:0], q.held};
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level_out = (delay == `DLY_NONE) ? q.held : q.line[delay - `DLY_ONE];
endmodule : pwm_leg_shaper

/* verif/pwm_bridge_model.sv */
// Model of the external bridge stage on the minus legs.
// Assumes the minus pin has a pull-down whenever the leg is released.
`timescale 1ns/1ps
module pwm_bridge_model (
	input wire logic [5:0] negative_output,
	input wire logic [5:0] negative_enable,
	output logic [5:0] neg_pin
);
	// A released leg falls to the pull-down instead of keeping its last level.
	assign neg_pin = ~negative_enable & negative_output;
endmodule : pwm_bridge_model

/* verif/pwm_stage_checker.sv */
// Checker for the host port and leg pacing of the PWM output stage.
// Assumes it is bound to the stage top and sees only its ports.
`timescale 1ns/1ps
`include "pwm_stage_map.svh"
module pwm_stage_checker (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic modulator_power_down,
	input wire logic mclk_en,
	input wire logic oversample_rate_select,
	input wire logic [5:0] positive_output,
	input wire logic [5:0] negative_output,
	input wire logic [5:0] negative_enable
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_run; !modulator_power_down && !mclk_en ##1 !modulator_power_down; endsequence
	sequence s_rd(a); reg_rd && reg_addr == a; endsequence
	property p_unmap; reg_rd && (reg_addr < 8'h31 || reg_addr > 8'h33) |=> reg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_cfg_res; s_rd(8'h31) |=> (reg_rdata & ~`CFG_WRITE_MASK) == 8'h00; endproperty
	a_cfg_res: assert property (p_cfg_res) else $error("config reserved bit set");
	property p_minp_res; s_rd(8'h32) |=> (reg_rdata & ~`MINP_WRITE_MASK) == 8'h00; endproperty
	a_minp_res: assert property (p_minp_res) else $error("pulse reserved bit set");
	property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_pd_off; modulator_power_down[*3] |-> positive_output == 6'h00; endproperty
	a_pd_off: assert property (p_pd_off) else $error("output while powered down");
	property p_rate; (!modulator_power_down)[*3] |-> $stable(oversample_rate_select); endproperty
	a_rate: assert property (p_rate) else $error("rate moved while running");
	property p_pos_pace; s_run |=> $stable(positive_output); endproperty
	a_pos_pace: assert property (p_pos_pace) else $error("plus leg off pace");
	property p_neg_pace; s_run |=> $stable(negative_output); endproperty
	a_neg_pace: assert property (p_neg_pace) else $error("minus leg off pace");
	property p_pd_neg; modulator_power_down[*2] |-> negative_enable == 6'h3F && negative_output == 6'h00;
	endproperty
	a_pd_neg: assert property (p_pd_neg) else $error("minus leg driven while powered down");
endmodule : pwm_stage_checker
bind pwm_output_stage pwm_stage_checker u_pwm_stage_checker (.core_clk(core_clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mclk_en(mclk_en),
	.modulator_power_down(modulator_power_down), .oversample_rate_select(oversample_rate_select),
	.positive_output(positive_output), .negative_output(negative_output),
	.negative_enable(negative_enable));

/* verif/pwm_output_stage_config_tb.sv */
// Testbench for the PWM output stage: register port, bridge modes and skews.
// Assumes a modulator clock enable of one pulse every four core cycles.
`timescale 1ns/1ps
module pwm_output_stage_config_tb;
	logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, pd = 1, mclk_en = 0, rate;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [5:0] mod_level = 6'h00, pos, neg, neg_en, neg_pin;
	int n_mismatch = 0, comparisons = 0, i, t_b, t_a, t_n;
	pwm_output_stage u_pwm_output_stage (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.modulator_power_down(pd), .mclk_en(mclk_en), .mod_level(mod_level),
		.oversample_rate_select(rate), .positive_output(pos), .negative_output(neg),
		.negative_enable(neg_en));
	pwm_bridge_model u_pwm_bridge_model (.negative_output(neg), .negative_enable(neg_en),
		.neg_pin(neg_pin));
	always #5 core_clk = ~core_clk;
	initial forever begin
		repeat (3) @(posedge core_clk);
		#1 mclk_en = 1;
		@(posedge core_clk);
		#1 mclk_en = 0;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge core_clk);
		#1 reg_wr = 0;
		@(posedge core_clk);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1;
		@(posedge core_clk);
		#1 reg_rd = 0;
		chk("rdata", reg_rdata, exp);
		@(posedge core_clk);
		#1;
	endtask : rd
	task automatic sel(input logic [7:0] c, input logic [5:0] exp);
		pd = 1;
		wr(8'h31, c);
		pd = 0;
		repeat (2) @(posedge core_clk);
		#1 chk("neg_en", neg_en, exp);
	endtask : sel
	// Plus-leg rises and the minus-pin fall are timed from the same edge, so the differences are whole periods.
	task automatic meas(input int len);
		t_b = -1;
		t_a = -1;
		t_n = 0;
		mod_level = 6'h3F;
		for (i = 0; i < 300; i++) begin
			@(posedge core_clk);
			#1 if (len > 0 && i == len) mod_level = 6'h00;
			if (t_b < 0 && pos[1]) t_b = i;
			if (t_a < 0 && pos[0]) t_a = i;
			if (len > 0) t_n += pos[1];
			else if (t_n == 0 && !neg_pin[1]) t_n = i;
		end
	endtask : meas
	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (8) @(posedge core_clk);
		#1 nrst = 1;
		wr(8'h31, 8'hFF);
		rd(8'h31, 8'h9E);
		wr(8'h32, 8'hFF);
		rd(8'h32, 8'h9F);
		wr(8'h33, 8'h43);
		rd(8'h33, 8'h43);
		rd(8'h40, 8'h00);
		pd = 0;
		wr(8'h31, 8'h00);
		rd(8'h31, 8'h9E);
		chk("rate", rate, 1);
		chk("neg_en", neg_en, 6'h00);
		pd = 1;
		wr(8'h31, 8'h00);
		wr(8'h32, 8'h80);
		pd = 0;
		repeat (4) @(posedge core_clk);
		#1 chk("rate", rate, 0);
		chk("neg_en", neg_en, 6'h3F);
		sel(8'h10, 6'h3C);
		sel(8'h08, 6'h33);
		sel(8'h04, 6'h2F);
		sel(8'h02, 6'h1F);
		pd = 1;
		wr(8'h32, 8'h00);
		sel(8'h00, 6'h00);
		sel(8'h1E, 6'h00);
		repeat (200) @(posedge core_clk);
		#1 meas(0);
		chk("leg_skew", t_n - t_b, 8);
		chk("pair_skew", t_a - t_b, 12);
		mod_level = 6'h00;
		pd = 1;
		wr(8'h32, 8'h02);
		pd = 0;
		repeat (200) @(posedge core_clk);
		#1 meas(3);
		chk("min_pulse", t_n, 8);
		end_sim();
	end
endmodule : pwm_output_stage_config_tb
